// [verilog/vic_ctrl.sv]
// vectored interrupt controller with its register slave and sequencer
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module vic_ctrl
  import vic_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             srst_in,
  // ahb-lite slave
  input  wire logic             hsel_in,
  input  wire logic [31:0]      haddr_in,
  input  wire logic [1:0]       htrans_in,
  input  wire logic             hwrite_in,
  input  wire logic [2:0]       hsize_in,
  input  wire logic [31:0]      hwdata_in,
  input  wire logic             hready_in,
  output logic      [31:0]      hrdata_out,
  output logic                  hreadyout_out,
  output logic                  hresp_out,
  // interrupt sources
  input  wire logic [NSRC-1:0]  src_event_in,
  input  wire logic             ext_pin_irq_one_in,
  input  wire logic             ext_pin_irq_two_in,
  input  wire logic             ext_pin_irq_three_in,
  input  wire logic             timer5_ovf_in,
  input  wire logic             timer6_ovf_in,
  // processor core
  input  wire logic             software_break_instruction_in,
  input  wire logic             core_iflag_in,
  input  wire logic [7:0]       program_counter_high_in,
  input  wire logic [7:0]       program_counter_low_in,
  input  wire logic [7:0]       processor_status_word_in,
  output logic                  stack_we_out,
  output logic      [7:0]       stack_data_out,
  output logic                  mem_rd_out,
  output logic      [15:0]      mem_addr_out,
  input  wire logic [7:0]       mem_rdata_in,
  output logic                  pc_load_out,
  output logic      [15:0]      pc_value_out,
  output logic                  iflag_set_out,
  output logic                  busy_out,
  output logic                  irq_out
);

  // vector of a maskable pick, or of the break instruction
  function automatic logic [15:0] vec_of(input logic [NSRC-1:0] pick,
                                         input logic is_break);
    logic [15:0] v;
    v = VEC_RESET;
    for (int i = 0; i < NSRC; i++) begin
      if (pick[i]) v = VEC_RESET - VEC_STEP * 16'(i + 1);
    end
    return is_break ? VEC_BREAK : v;
  endfunction

  logic [NSRC-1:0] req_q;              // request bits
  logic [NSRC-1:0] ena_q;              // enable bits
  logic [NPIN-1:0] pol_q;              // pin polarity bits
  logic            tsel_q;             // 0 timer 5, 1 timer 6
  logic [2:0]      evt_q;              // sticky event status
  logic [2:0]      evt_en_q;           // event enables
  logic            break_pend_q;       // break waiting for service
  vic_state_e      state_q;            // sequencer state
  logic [15:0]     vec_q;              // vector being fetched
  logic [7:0]      lo_q;               // fetched low byte
  logic            stack_we_q;
  logic [7:0]      stack_data_q;
  logic            mem_rd_q;
  logic [15:0]     mem_addr_q;
  logic            pc_load_q;
  logic [15:0]     pc_value_q;
  logic            iflag_set_q;
  logic [31:0]     hrdata_q;
  logic            wr_pend_q;          // write data phase follows
  logic [7:0]      wr_ofs_q;           // its offset

  // bus decode in the address phase
  logic        ap_valid;
  logic [7:0]  ap_ofs;
  assign ap_valid = hsel_in && htrans_in[1] && hready_in;
  assign ap_ofs   = {haddr_in[7:2], 2'b00};

  // data phase write strobes
  logic wr_req, wr_ena, wr_pol, wr_tsel, wr_iclr, wr_iena;
  assign wr_req  = wr_pend_q && (wr_ofs_q == OFS_REQ);
  assign wr_ena  = wr_pend_q && (wr_ofs_q == OFS_ENA);
  assign wr_pol  = wr_pend_q && (wr_ofs_q == OFS_POL);
  assign wr_tsel = wr_pend_q && (wr_ofs_q == OFS_TSEL);
  assign wr_iclr = wr_pend_q && (wr_ofs_q == OFS_ICLR);
  assign wr_iena = wr_pend_q && (wr_ofs_q == OFS_IENA);

  // hardware set sources: edges, timers, plain internal pulses
  logic [NPIN-1:0] pin_edge;
  logic [NSRC-1:0] set_vec;
  logic            tsw;                // selection flip
  vic_edge #(.W(NPIN)) vic_edge_inst (
    .clk_in   (clk_in),
    .srst_in  (srst_in),
    .pin_in   ({ext_pin_irq_three_in, ext_pin_irq_two_in,
                ext_pin_irq_one_in}),
    .pol_in   (pol_q),
    .edge_out (pin_edge)
  );
  assign tsw = wr_tsel && (hwdata_in[0] != tsel_q);
  always_comb begin
    set_vec = src_event_in;
    set_vec[IDX_EXT_ONE] = pin_edge[0];
    set_vec[IDX_EXT_TWO] = pin_edge[1];
    set_vec[IDX_EXT_THR] = pin_edge[2];
    set_vec[IDX_TMR56]   = (tsel_q ? timer6_ovf_in : timer5_ovf_in)
                         || tsw;
  end

  // priority pick among eligible sources
  logic [NSRC-1:0] pend;
  logic            pick_valid, pick_break;
  logic [NSRC-1:0] pick;
  logic            accept;
  assign pend = req_q & ena_q & {NSRC{!core_iflag_in}};
  vic_prio #(.N(NSRC)) vic_prio_inst (
    .pend_in   (pend),
    .break_in  (break_pend_q),
    .valid_out (pick_valid),
    .break_out (pick_break),
    .pick_out  (pick)
  );
  // only taken between sequences, so reset service is never preempted
  assign accept = (state_q == VIC_IDLE) && pick_valid;

  // request bits: hardware set beats both clears
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      req_q <= RST_REQ;
    end else begin
      req_q <= ((req_q
               & ~(wr_req ? ~hwdata_in[NSRC-1:0] : '0))
               & ~(accept ? pick : '0))
               | set_vec;
    end
  end

  // enable, polarity and timer select, plain software state
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ena_q  <= RST_ENA;
      pol_q  <= RST_POL;
      tsel_q <= 1'b0;
    end else begin
      if (wr_ena) ena_q <= hwdata_in[NSRC-1:0];
      if (wr_pol) pol_q <= hwdata_in[NPIN-1:0];
      if (wr_tsel) tsel_q <= hwdata_in[0];
    end
  end

  // break instruction waits until served; no enable and no flag
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      break_pend_q <= 1'b0;
    end else if (software_break_instruction_in) begin
      break_pend_q <= 1'b1;
    end else if (accept && pick_break) begin
      break_pend_q <= 1'b0;
    end
  end

  // sticky event status, set wins over clear
  logic [2:0] evt_set;
  assign evt_set = {tsw, accept && pick_break, accept && !pick_break};
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      evt_q    <= RST_EVT;
      evt_en_q <= RST_EVT;
    end else begin
      evt_q <= (evt_q & ~(wr_iclr ? hwdata_in[2:0] : 3'h0)) | evt_set;
      if (wr_iena) evt_en_q <= hwdata_in[2:0];
    end
  end

  // interrupt line registered from status and enable
  always_ff @(posedge clk_in) begin
    if (srst_in) irq_out <= 1'b0;
    else         irq_out <= |(evt_q & evt_en_q);
  end

  // acceptance sequencer: push pc high, pc low, status, fetch vector
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_q     <= VIC_FETCH_L;
      vec_q       <= VEC_RESET;
      mem_rd_q    <= 1'b1;
      mem_addr_q  <= VEC_RESET;
      stack_we_q  <= 1'b0;
      stack_data_q <= 8'h00;
      lo_q        <= 8'h00;
      pc_load_q   <= 1'b0;
      pc_value_q  <= 16'h0000;
      iflag_set_q <= 1'b0;
    end else begin
      case (state_q)
        VIC_IDLE: begin
          if (accept) begin
            state_q      <= VIC_PUSH_H;
            vec_q        <= vec_of(pick, pick_break);
            stack_we_q   <= 1'b1;
            stack_data_q <= program_counter_high_in;
          end
        end
        VIC_PUSH_H: begin
          state_q      <= VIC_PUSH_L;
          stack_data_q <= program_counter_low_in;
        end
        VIC_PUSH_L: begin
          state_q      <= VIC_PUSH_P;
          stack_data_q <= processor_status_word_in;
        end
        VIC_PUSH_P: begin
          // stacking done before any fetch is issued
          state_q    <= VIC_FETCH_L;
          stack_we_q <= 1'b0;
          mem_rd_q   <= 1'b1;
          mem_addr_q <= vec_q;
        end
        VIC_FETCH_L: begin
          // memory answers one cycle after the address
          state_q    <= VIC_FETCH_H;
          mem_addr_q <= vec_q + 16'h0001;
        end
        VIC_FETCH_H: begin
          state_q  <= VIC_LOAD;
          lo_q     <= mem_rdata_in;
          mem_rd_q <= 1'b0;
        end
        VIC_LOAD: begin
          state_q     <= VIC_DONE;
          pc_load_q   <= 1'b1;
          pc_value_q  <= {mem_rdata_in, lo_q};
          iflag_set_q <= 1'b1;
        end
        VIC_DONE: begin
          // one spare cycle lets the core's flag settle before idle
          state_q     <= VIC_IDLE;
          pc_load_q   <= 1'b0;
          iflag_set_q <= 1'b0;
        end
        default: state_q <= VIC_IDLE;
      endcase
    end
  end

  // ahb-lite slave: zero wait states, okay always, reads registered
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q  <= 8'h00;
      hrdata_q  <= 32'h0000_0000;
    end else begin
      wr_pend_q <= ap_valid && hwrite_in;
      wr_ofs_q  <= ap_ofs;
      if (ap_valid && !hwrite_in) begin
        case (ap_ofs)
          OFS_REQ:   hrdata_q <= 32'(req_q);
          OFS_ENA:   hrdata_q <= 32'(ena_q);
          OFS_POL:   hrdata_q <= 32'(pol_q);
          OFS_TSEL:  hrdata_q <= 32'(tsel_q);
          OFS_ISTAT: hrdata_q <= 32'(evt_q);
          OFS_IENA:  hrdata_q <= 32'(evt_en_q);
          OFS_STATE: hrdata_q <= 32'({break_pend_q, state_q});
          default:   hrdata_q <= 32'h0000_0000;   // unmapped, clear
        endcase
      end
    end
  end

  assign hrdata_out     = hrdata_q;
  assign hreadyout_out  = 1'b1;        // constant, never stalls
  assign hresp_out      = 1'b0;        // constant okay
  assign stack_we_out   = stack_we_q;
  assign stack_data_out = stack_data_q;
  assign mem_rd_out     = mem_rd_q;
  assign mem_addr_out   = mem_addr_q;
  assign pc_load_out    = pc_load_q;
  assign pc_value_out   = pc_value_q;
  assign iflag_set_out  = iflag_set_q;
  assign busy_out       = (state_q != VIC_IDLE);

  // checks
  a_push_three_bytes: assert property (@(posedge clk_in)
    disable iff (srst_in) accept |=> stack_we_out [*3] ##1 !stack_we_out)
    else $error("stacking is not three bytes");
  a_load_sets_flag: assert property (@(posedge clk_in)
    disable iff (srst_in) $rose(pc_load_out) |-> iflag_set_out)
    else $error("pc load without disable flag set");
  a_req_cleared: assert property (@(posedge clk_in)
    disable iff (srst_in) accept && !pick_break
    |=> (req_q & $past(pick) & ~$past(set_vec)) == '0)
    else $error("accepted request bit still set");
  a_flag_blocks: assert property (@(posedge clk_in)
    disable iff (srst_in) accept && !pick_break |-> !core_iflag_in)
    else $error("maskable accepted with flag set");
  a_accept_eligible: assert property (@(posedge clk_in)
    disable iff (srst_in) accept && !pick_break
    |-> (pick & req_q & ena_q) != '0)
    else $error("accepted source not requested and enabled");
  a_sw_never_sets: assert property (@(posedge clk_in)
    disable iff (srst_in)
    ##1 (req_q & ~$past(req_q) & ~$past(set_vec)) == '0)
    else $error("request bit set without hardware event");
  a_hw_sets_req: assert property (@(posedge clk_in)
    disable iff (srst_in) set_vec != '0 |=> ($past(set_vec) & ~req_q) == '0)
    else $error("hardware event lost");
  a_reset_vector: assert property (@(posedge clk_in)
    srst_in ##1 !srst_in |-> mem_rd_out && mem_addr_out == VEC_RESET
    ##1 mem_addr_out == VEC_RESET + 16'h0001)
    else $error("reset vector fetch wrong");
  a_prio_order: assert property (@(posedge clk_in)
    disable iff (srst_in) accept && !pick_break
    |-> (pend & (pick - 14'h0001)) == '0)
    else $error("lower priority served first");

endmodule
`default_nettype wire

// [verilog/vic_pkg.sv]
// constants, register map and states of the vectored interrupt controller
package vic_pkg;

  localparam int unsigned NSRC        = 14;       // sources with request bits
  localparam int unsigned NPIN        = 3;        // external edge pins
  // request bit positions, highest priority at bit 0
  localparam int unsigned IDX_EXT_ONE = 1;
  localparam int unsigned IDX_EXT_THR = 10;
  localparam int unsigned IDX_EXT_TWO = 11;
  localparam int unsigned IDX_TMR56   = 13;

  // register byte offsets
  localparam logic [7:0] OFS_REQ      = 8'h00;    // request bits
  localparam logic [7:0] OFS_ENA      = 8'h04;    // enable bits
  localparam logic [7:0] OFS_POL      = 8'h08;    // pin polarity
  localparam logic [7:0] OFS_TSEL     = 8'h0c;    // shared timer select
  localparam logic [7:0] OFS_ISTAT    = 8'h10;    // sticky event status
  localparam logic [7:0] OFS_ICLR     = 8'h14;    // write one to clear
  localparam logic [7:0] OFS_IENA     = 8'h18;    // event enable
  localparam logic [7:0] OFS_STATE    = 8'h1c;    // sequencer state

  // reset values
  localparam logic [NSRC-1:0] RST_REQ  = 14'h0000;
  localparam logic [NSRC-1:0] RST_ENA  = 14'h0000;
  localparam logic [NPIN-1:0] RST_POL  = 3'h0;
  localparam logic [2:0]      RST_EVT  = 3'h0;

  // event status bits
  localparam int unsigned EVT_ACCEPT = 0;         // maskable source taken
  localparam int unsigned EVT_BREAK  = 1;         // break instruction taken
  localparam int unsigned EVT_SWITCH = 2;         // timer source switched

  // vector addresses (low byte; high byte sits one above)
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_BREAK = 16'hffde;
  localparam logic [15:0] VEC_STEP  = 16'h0002;

  // acceptance sequencer
  typedef enum logic [2:0] {
    VIC_IDLE    = 3'b000,
    VIC_PUSH_H  = 3'b001,
    VIC_PUSH_L  = 3'b010,
    VIC_PUSH_P  = 3'b011,
    VIC_FETCH_L = 3'b100,
    VIC_FETCH_H = 3'b101,
    VIC_LOAD    = 3'b110,
    VIC_DONE    = 3'b111
  } vic_state_e;

endpackage

// [verilog/vic_edge.sv]
// edge detectors for the external interrupt pins
`timescale 1ns/1ps
`default_nettype none
module vic_edge #(
  parameter int unsigned W = 3
) (
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  input  wire logic [W-1:0] pin_in,    // pin levels, synchronous
  input  wire logic [W-1:0] pol_in,    // 0 rising, 1 falling
  output logic      [W-1:0] edge_out   // one-cycle pulse per edge
);

  logic [W-1:0] prev_q;                // pin level last cycle
  logic         armed_q;               // prev_q holds a real sample

  // sample history; the first cycle after reset sees no edge at all
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      prev_q  <= '0;
      armed_q <= 1'b0;
    end else begin
      prev_q  <= pin_in;
      armed_q <= 1'b1;
    end
  end

  // one detector per pin, polarity picks the direction
  for (genvar g = 0; g < W; g++) begin : g_pin
    assign edge_out[g] = armed_q &&
      (pol_in[g] ? (prev_q[g] && !pin_in[g])
                 : (!prev_q[g] && pin_in[g]));
  end

endmodule
`default_nettype wire

// [verilog/vic_prio.sv]
// fixed priority pick among pending sources
`timescale 1ns/1ps
`default_nettype none
module vic_prio #(
  parameter int unsigned N = 14
) (
  input  wire logic [N-1:0] pend_in,   // eligible maskable requests
  input  wire logic         break_in,  // break instruction pending
  output logic              valid_out, // something to accept
  output logic              break_out, // break is the pick
  output logic      [N-1:0] pick_out   // one-hot pick, maskable only
);

  // lowest index wins; break only when no maskable source waits
  always_comb begin
    pick_out = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend_in[i]) begin
        pick_out = '0;
        pick_out[i] = 1'b1;
      end
    end
    break_out = break_in && (pend_in == '0);
    valid_out = (pend_in != '0) || break_in;
  end

endmodule
`default_nettype wire

// [testbench/vic_core_model.sv]
// core and vector memory model that faces the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        mem_rd_in,     // vector fetch strobe
  input  wire logic [15:0] mem_addr_in,   // vector fetch address
  output logic      [7:0]  mem_rdata_out, // byte one cycle after address
  input  wire logic        iflag_set_in,  // set pulse from the controller
  input  wire logic        iflag_clr_in,  // bench clears, like a cli
  output logic             iflag_out      // interrupt-disable flag
);
  // one-cycle memory; between reads it inverts its byte every cycle,
  // so a byte taken one cycle late can never pass for a fresh vector fetch
  always_ff @(posedge clk_in) begin
    if (mem_rd_in) begin
      mem_rdata_out <= mem_addr_in[7:0] ^ mem_addr_in[15:8] ^ 8'h3c;
    end else begin
      mem_rdata_out <= ~mem_rdata_out;
    end
  end

  // disable flag: set on reset and on every acceptance, cleared on request
  always_ff @(posedge clk_in) begin
    if (srst_in || iflag_set_in) begin
      iflag_out <= 1'b1;
    end else if (iflag_clr_in) begin
      iflag_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [testbench/vectored_interrupt_control_tb.sv]
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  mismatches++; $display("unexpected %s exp %h got %h", n, e, g); end end
module vectored_interrupt_control_tb;
  import vic_pkg::*;
  logic            clk_in, srst_in, hwrite, iflag, clr, soft_break, t5, t6;
  logic            hready, hresp, stk_we, mem_rd, pc_load, iset, busy, irq;
  logic [1:0]      htrans;
  logic [2:0]      pin;        // three, two, one
  logic [7:0]      stk_d, mem_d;
  logic [15:0]     mem_a, pc_v;
  logic [31:0]     haddr, hwdata, hrdata, rd;
  logic [NSRC-1:0] evt;
  logic [7:0]      q[$];       // bytes pushed to the stack
  int              mismatches, tests_run;

  vic_ctrl vic_ctrl_inst (
    .clk_in(clk_in), .srst_in(srst_in), .hsel_in(1'b1), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .src_event_in(evt),
    .ext_pin_irq_one_in(pin[0]), .ext_pin_irq_two_in(pin[1]),
    .ext_pin_irq_three_in(pin[2]), .timer5_ovf_in(t5), .timer6_ovf_in(t6),
    .software_break_instruction_in(soft_break), .core_iflag_in(iflag),
    .program_counter_high_in(8'h12), .program_counter_low_in(8'h34),
    .processor_status_word_in(8'ha5), .stack_we_out(stk_we),
    .stack_data_out(stk_d), .mem_rd_out(mem_rd), .mem_addr_out(mem_a),
    .mem_rdata_in(mem_d), .pc_load_out(pc_load), .pc_value_out(pc_v),
    .iflag_set_out(iset), .busy_out(busy), .irq_out(irq));

  vic_core_model vic_core_model_inst (
    .clk_in(clk_in), .srst_in(srst_in), .mem_rd_in(mem_rd),
    .mem_addr_in(mem_a), .mem_rdata_out(mem_d), .iflag_set_in(iset),
    .iflag_clr_in(clr), .iflag_out(iflag));

  // clock at 250 MHz
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // capture stacked bytes; sampled before the edge's own updates land
  always @(posedge clk_in) if (stk_we === 1'b1) q.push_back(stk_d);

  // expected memory byte, worked out independently of the model
  function automatic logic [7:0] vb(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // one ahb-lite single word transfer; waits on hready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_in); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_in); while (hready !== 1'b1);
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK("register", e, rd)
  endtask

  // one-cycle pulse on {clr, soft_break, t6, t5, evt}
  task automatic pulse(input logic [NSRC+3:0] v);
    @(posedge clk_in);
    {clr, soft_break, t6, t5, evt} <= v;
    @(posedge clk_in);
    {clr, soft_break, t6, t5, evt} <= '0;
  endtask

  // wait for a program counter load and check vector and stacked bytes
  task automatic serve(input logic [15:0] v, input bit stk);
    int n;
    n = 0;
    while (pc_load !== 1'b1 && n < 60) begin
      @(posedge clk_in);
      n++;
    end
    `CHK("pc_load", 1'b1, pc_load)
    `CHK("pc_value", {vb(v + 16'h1), vb(v)}, pc_v)
    `CHK("stack", stk ? 24'h1234a5 : 24'h0,
         q.size() == 3 ? {q[0], q[1], q[2]} : 24'h0)
    q.delete();
    @(posedge clk_in);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // watchdog: the sequence needs under 500 cycles, allow far more
  initial begin
    #60000;
    mismatches++;
    finish_test();
  end

  initial begin
    srst_in = 1'b1;
    {clr, soft_break, t6, t5, evt, pin, htrans, hwrite} = '0;
    {haddr, hwdata} = '0;
    cyc(4);
    srst_in <= 1'b0;
    serve(16'hfffe, 1'b0);
    rchk(OFS_REQ, 32'h0);
    rchk(OFS_ENA, 32'h0);
    rchk(OFS_POL, 32'h0);
    bus(1'b1, OFS_ENA, 32'h3fff);
    rchk(OFS_ENA, 32'h3fff);
    bus(1'b1, OFS_ENA, 32'h0);
    rchk(OFS_ENA, 32'h0);
    // a disabled source still latches its request
    pulse(18'h00020);
    rchk(OFS_REQ, 32'h20);
    bus(1'b1, OFS_REQ, 32'h3fff);
    rchk(OFS_REQ, 32'h20);
    bus(1'b1, OFS_REQ, 32'h0);
    rchk(OFS_REQ, 32'h0);
    // timer slot with its reset selection: timer 5 counts, timer 6 not
    pulse(18'h08000);
    rchk(OFS_REQ, 32'h0);
    pulse(18'h04000);
    rchk(OFS_REQ, 32'h2000);
    // pin three falling only; pins one and two rising
    bus(1'b1, OFS_POL, 32'h4);
    bus(1'b1, OFS_REQ, 32'h0);
    @(posedge clk_in);
    pin <= 3'b100;
    cyc(3);
    rchk(OFS_REQ, 32'h0);
    @(posedge clk_in);
    pin <= 3'b011;
    cyc(3);
    rchk(OFS_REQ, 32'h0c02);
    // shared timer slot: switching raises a request
    bus(1'b1, OFS_TSEL, 32'h1);
    rchk(OFS_REQ, 32'h2c02);
    bus(1'b1, OFS_REQ, 32'h0);
    pulse(18'h04000);
    rchk(OFS_REQ, 32'h0);
    pulse(18'h08000);
    rchk(OFS_REQ, 32'h2000);
    // two enabled plus one disabled pending while the flag is set
    bus(1'b1, OFS_REQ, 32'h0);
    bus(1'b1, OFS_ENA, 32'h88);
    pulse(18'h00288);
    cyc(10);
    `CHK("busy", 1'b0, busy)
    pulse(18'h20000);
    serve(16'hfff6, 1'b1);
    rchk(OFS_REQ, 32'h280);
    `CHK("iflag", 1'b1, iflag)
    cyc(10);
    `CHK("busy", 1'b0, busy)
    pulse(18'h20000);
    serve(16'hffee, 1'b1);
    rchk(OFS_REQ, 32'h200);
    pulse(18'h10000);
    serve(16'hffde, 1'b1);
    // break and an enabled source together: the source goes first
    pulse(18'h30080);
    serve(16'hffee, 1'b1);
    serve(16'hffde, 1'b1);
    // every internal source through its own vector
    bus(1'b1, OFS_REQ, 32'h0);
    bus(1'b1, OFS_ENA, 32'h3fff);
    for (int i = 0; i < 14; i++) begin
      if (!(i inside {1, 10, 11, 13})) begin
        pulse(18'(1 << i) | 18'h20000);
        serve(16'hfffe - 16'(2 * (i + 1)), 1'b1);
      end
    end
    // sticky events, enable mask and clear
    rchk(OFS_ISTAT, 32'h7);
    bus(1'b1, OFS_IENA, 32'h2);
    cyc(2);
    `CHK("irq", 1'b1, irq)
    bus(1'b1, OFS_IENA, 32'h0);
    cyc(2);
    `CHK("irq", 1'b0, irq)
    bus(1'b1, OFS_ICLR, 32'h7);
    rchk(OFS_ISTAT, 32'h0);
    bus(1'b1, OFS_IENA, 32'h7);
    cyc(2);
    `CHK("irq", 1'b0, irq)
    rchk(8'h40, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
